// File: include/dsl_pkg.sv
/*
 * constants, reset values and register map of the digital setpoint latch.
 * assumes a 20 MHz sys_clk and a plain strobe-based register port.
 */
package dsl_pkg;
    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int unsigned DSL_LINES_W = 12;
    localparam int unsigned DSL_SET_W   = 16;
    localparam int unsigned DSL_ADDR_W  = 4;
    localparam int unsigned DSL_UNIT_W  = 2;
    localparam int unsigned DSL_DIGIT_W = 4;

    // ----------------------------------------------------------------
    // setting codes
    // ----------------------------------------------------------------
    localparam logic [15:0] DSL_TYPE_BCD      = 16'h0000;
    localparam logic [15:0] DSL_TYPE_BIN      = 16'h0001;
    localparam logic [15:0] DSL_TYPE_BCD_COMP = 16'h0002;
    localparam logic [15:0] DSL_TYPE_BIN_COMP = 16'h0003;
    localparam logic [15:0] DSL_TYPE_DISABLED = 16'd9999;
    localparam logic [15:0] DSL_GAIN_PASS     = 16'd9999;
    localparam logic [15:0] DSL_STROBE_CONT   = 16'h0000;
    localparam logic [15:0] DSL_STROBE_GATED  = 16'h0001;
    localparam logic [15:0] DSL_UNIT_MAX      = 16'h0002;
    localparam logic [15:0] DSL_PERM_LOCKED   = 16'h0001;
    localparam logic [15:0] DSL_PERM_MAX      = 16'h0002;
    localparam logic [15:0] DSL_SETTING_MAX   = 16'd40000;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] DSL_TYPE_RST   = DSL_TYPE_DISABLED;
    localparam logic [15:0] DSL_STROBE_RST = DSL_STROBE_CONT;
    localparam logic [15:0] DSL_UNIT_RST   = 16'h0001;
    localparam logic [15:0] DSL_PERM_RST   = 16'h0000;
    localparam logic [15:0] DSL_BIAS_RST   = 16'h0000;
    localparam logic [15:0] DSL_GAIN_RST   = 16'd6000;

    // ----------------------------------------------------------------
    // full-scale input words
    // ----------------------------------------------------------------
    localparam logic [11:0] DSL_BCD_FULL = 12'd999;
    localparam logic [11:0] DSL_BIN_FULL = 12'hfff;
    localparam logic [3:0]  DSL_DIGIT_MAX = 4'h9;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [3:0] DSL_A_TYPE     = 4'h0;
    localparam logic [3:0] DSL_A_STROBE   = 4'h1;
    localparam logic [3:0] DSL_A_UNIT     = 4'h2;
    localparam logic [3:0] DSL_A_PERM     = 4'h3;
    localparam logic [3:0] DSL_A_BCD_BIAS = 4'h4;
    localparam logic [3:0] DSL_A_BCD_GAIN = 4'h5;
    localparam logic [3:0] DSL_A_BIN_BIAS = 4'h6;
    localparam logic [3:0] DSL_A_BIN_GAIN = 4'h7;
    localparam logic [3:0] DSL_A_RAW      = 4'h8;
    localparam logic [3:0] DSL_A_SETPOINT = 4'h9;
    localparam logic [3:0] DSL_A_STATUS   = 4'ha;

    // status bit positions
    localparam int unsigned DSL_ST_ACTIVE  = 0;
    localparam int unsigned DSL_ST_VALID   = 1;
    localparam int unsigned DSL_ST_PASS    = 2;
    localparam int unsigned DSL_ST_COMP    = 3;
    localparam int unsigned DSL_ST_BCD_ERR = 4;
endpackage

// File: rtl/dsl_sync.sv
/*
 * two-flop synchroniser for a bundle of asynchronous pins.
 * assumes the bundle is re-checked for a consistent word downstream.
 */
`timescale 1ns/100ps
module dsl_sync #(
    parameter int unsigned WIDTH = 13
) (
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async_in,
    output      logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    if (WIDTH < 1) begin
        $error("dsl_sync: WIDTH must be at least 1");
    end

    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule

// File: rtl/dsl_setpoint_latch.sv
/*
 * digital setpoint input latch: twelve parallel lines decoded as bcd or
 * binary, optionally gated by a read strobe, scaled by bias and gain.
 * assumes pins are asynchronous and drive_running comes from sys_clk logic.
 */
`timescale 1ns/100ps
module dsl_setpoint_latch (
    input  wire logic                            sys_clk,
    input  wire logic                            resetn,
    input  wire logic [dsl_pkg::DSL_ADDR_W-1:0]  reg_addr,
    input  wire logic [dsl_pkg::DSL_SET_W-1:0]   reg_wdata,
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    output      logic [dsl_pkg::DSL_SET_W-1:0]   reg_rdata,
    input  wire logic [dsl_pkg::DSL_LINES_W-1:0] setpoint_input_lines,
    input  wire logic                            read_strobe,
    input  wire logic                            drive_running,
    output      logic [dsl_pkg::DSL_SET_W-1:0]   setpoint_value,
    output      logic                            setpoint_valid,
    output      logic                            compensation_enable,
    output      logic [dsl_pkg::DSL_UNIT_W-1:0]  speed_unit,
    output      logic                            input_active
);
    import dsl_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic bcd_ok(input logic [11:0] w);
        return (w[3:0] <= DSL_DIGIT_MAX) && (w[7:4] <= DSL_DIGIT_MAX)
            && (w[11:8] <= DSL_DIGIT_MAX);
    endfunction

    function automatic logic [11:0] bcd_value(input logic [11:0] w);
        logic [11:0] hundreds;
        logic [11:0] tens;
        hundreds = 12'(w[11:8]) * 12'd100;
        tens     = 12'(w[7:4]) * 12'd10;
        return hundreds + tens + 12'(w[3:0]);
    endfunction

    // linear map: 0 -> bias, full -> gain, either slope direction
    function automatic logic [15:0] scale(input logic [11:0] raw,
                                          input logic [11:0] full,
                                          input logic [15:0] bias,
                                          input logic [15:0] gain);
        logic [15:0] span;
        logic [27:0] prod;
        logic [15:0] step;
        span = (gain >= bias) ? gain - bias : bias - gain;
        prod = 28'(span) * 28'(raw);
        step = 16'(prod / 28'(full));
        return (gain >= bias) ? bias + step : bias - step;
    endfunction

    // ----------------------------------------------------------------
    // settings
    // ----------------------------------------------------------------
    logic [15:0] type_reg, type_next;
    logic [15:0] strobe_reg, strobe_next;
    logic [15:0] unit_reg, unit_next;
    logic [15:0] perm_reg, perm_next;
    logic [15:0] bcd_bias_reg, bcd_bias_next;
    logic [15:0] bcd_gain_reg, bcd_gain_next;
    logic [15:0] bin_bias_reg, bin_bias_next;
    logic [15:0] bin_gain_reg, bin_gain_next;
    logic [15:0] rdata_reg, rdata_next;
    logic        wr_ok;

    // ----------------------------------------------------------------
    // datapath state
    // ----------------------------------------------------------------
    logic [DSL_LINES_W:0] pins_sync;
    logic [11:0] word_prev_reg, word_prev_next;
    logic [11:0] raw_reg, raw_next;
    logic [15:0] setpoint_reg, setpoint_next;
    logic        valid_reg, valid_next;
    logic        bcd_err_reg, bcd_err_next;
    logic [11:0] word_s;
    logic        strobe_s;
    logic        active, is_bcd, pass, sample_en;
    logic [15:0] sel_bias, sel_gain, status;

    dsl_sync #(
        .WIDTH (DSL_LINES_W + 1)
    ) u_sync (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .async_in ({read_strobe, setpoint_input_lines}),
        .sync_out (pins_sync)
    );
    assign word_s   = pins_sync[DSL_LINES_W-1:0];
    assign strobe_s = pins_sync[DSL_LINES_W];

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    // a lock value in the permission setting freezes everything but itself
    always_comb begin
        type_next     = type_reg;
        strobe_next   = strobe_reg;
        unit_next     = unit_reg;
        perm_next     = perm_reg;
        bcd_bias_next = bcd_bias_reg;
        bcd_gain_next = bcd_gain_reg;
        bin_bias_next = bin_bias_reg;
        bin_gain_next = bin_gain_reg;
        wr_ok = reg_wr && (perm_reg != DSL_PERM_LOCKED || reg_addr == DSL_A_PERM);
        if (wr_ok) begin
            unique case (reg_addr)
                DSL_A_TYPE: begin
                    if (reg_wdata <= DSL_TYPE_BIN_COMP || reg_wdata == DSL_TYPE_DISABLED)
                        type_next = reg_wdata;
                end
                DSL_A_STROBE: begin
                    if (reg_wdata <= DSL_STROBE_GATED) strobe_next = reg_wdata;
                end
                DSL_A_UNIT: begin
                    // refused while running whatever the permission says
                    if (reg_wdata <= DSL_UNIT_MAX && !drive_running)
                        unit_next = reg_wdata;
                end
                DSL_A_PERM: begin
                    if (reg_wdata <= DSL_PERM_MAX) perm_next = reg_wdata;
                end
                DSL_A_BCD_BIAS: begin
                    if (reg_wdata <= DSL_SETTING_MAX) bcd_bias_next = reg_wdata;
                end
                DSL_A_BCD_GAIN: begin
                    if (reg_wdata <= DSL_SETTING_MAX || reg_wdata == DSL_GAIN_PASS)
                        bcd_gain_next = reg_wdata;
                end
                DSL_A_BIN_BIAS: begin
                    if (reg_wdata <= DSL_SETTING_MAX) bin_bias_next = reg_wdata;
                end
                DSL_A_BIN_GAIN: begin
                    if (reg_wdata <= DSL_SETTING_MAX || reg_wdata == DSL_GAIN_PASS)
                        bin_gain_next = reg_wdata;
                end
                default: ;
            endcase
        end
        rdata_next = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                DSL_A_TYPE:     rdata_next = type_reg;
                DSL_A_STROBE:   rdata_next = strobe_reg;
                DSL_A_UNIT:     rdata_next = unit_reg;
                DSL_A_PERM:     rdata_next = perm_reg;
                DSL_A_BCD_BIAS: rdata_next = bcd_bias_reg;
                DSL_A_BCD_GAIN: rdata_next = bcd_gain_reg;
                DSL_A_BIN_BIAS: rdata_next = bin_bias_reg;
                DSL_A_BIN_GAIN: rdata_next = bin_gain_reg;
                DSL_A_RAW:      rdata_next = 16'(raw_reg);
                DSL_A_SETPOINT: rdata_next = setpoint_reg;
                DSL_A_STATUS:   rdata_next = status;
                default:        rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            type_reg     <= DSL_TYPE_RST;
            strobe_reg   <= DSL_STROBE_RST;
            unit_reg     <= DSL_UNIT_RST;
            perm_reg     <= DSL_PERM_RST;
            bcd_bias_reg <= DSL_BIAS_RST;
            bcd_gain_reg <= DSL_GAIN_RST;
            bin_bias_reg <= DSL_BIAS_RST;
            bin_gain_reg <= DSL_GAIN_RST;
            rdata_reg    <= '0;
        end else begin
            type_reg     <= type_next;
            strobe_reg   <= strobe_next;
            unit_reg     <= unit_next;
            perm_reg     <= perm_next;
            bcd_bias_reg <= bcd_bias_next;
            bcd_gain_reg <= bcd_gain_next;
            bin_bias_reg <= bin_bias_next;
            bin_gain_reg <= bin_gain_next;
            rdata_reg    <= rdata_next;
        end
    end

    // ----------------------------------------------------------------
    // sampling, decode and scaling
    // ----------------------------------------------------------------
    always_comb begin
        active   = (type_reg != DSL_TYPE_DISABLED);
        is_bcd   = (type_reg == DSL_TYPE_BCD) || (type_reg == DSL_TYPE_BCD_COMP);
        sel_bias = is_bcd ? bcd_bias_reg : bin_bias_reg;
        sel_gain = is_bcd ? bcd_gain_reg : bin_gain_reg;
        pass     = (sel_gain == DSL_GAIN_PASS);
        // word must read the same twice so a skewed edge is never taken
        sample_en = active && (word_s == word_prev_reg)
                 && (strobe_reg == DSL_STROBE_CONT || strobe_s);
        word_prev_next = word_s;
        raw_next     = raw_reg;
        bcd_err_next = bcd_err_reg;
        valid_next   = active && valid_reg;
        if (sample_en) begin
            if (is_bcd && !bcd_ok(word_s)) begin
                bcd_err_next = 1'b1;
            end else begin
                raw_next     = is_bcd ? bcd_value(word_s) : word_s;
                bcd_err_next = 1'b0;
                valid_next   = 1'b1;
            end
        end
        if (!active) setpoint_next = '0;
        else if (pass) setpoint_next = 16'(raw_reg);
        else if (is_bcd)
            setpoint_next = scale(raw_reg, DSL_BCD_FULL, sel_bias, sel_gain);
        else
            setpoint_next = scale(raw_reg, DSL_BIN_FULL, sel_bias, sel_gain);
        status = '0;
        status[DSL_ST_ACTIVE]  = active;
        status[DSL_ST_VALID]   = valid_reg;
        status[DSL_ST_PASS]    = pass;
        status[DSL_ST_COMP]    = (type_reg == DSL_TYPE_BCD_COMP)
                              || (type_reg == DSL_TYPE_BIN_COMP);
        status[DSL_ST_BCD_ERR] = bcd_err_reg;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            word_prev_reg <= '0;
            raw_reg       <= '0;
            setpoint_reg  <= '0;
            valid_reg     <= 1'b0;
            bcd_err_reg   <= 1'b0;
        end else begin
            word_prev_reg <= word_prev_next;
            raw_reg       <= raw_next;
            setpoint_reg  <= setpoint_next;
            valid_reg     <= valid_next;
            bcd_err_reg   <= bcd_err_next;
        end
    end

    assign reg_rdata           = rdata_reg;
    assign setpoint_value      = setpoint_reg;
    assign setpoint_valid      = valid_reg;
    assign compensation_enable = status[DSL_ST_COMP];
    assign speed_unit          = unit_reg[DSL_UNIT_W-1:0];
    assign input_active        = active;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_inert_default: assert property (@(posedge sys_clk) disable iff (!resetn)
        (type_reg == DSL_TYPE_DISABLED) |=> (!setpoint_valid && setpoint_value == '0))
        else $error("setpoint live while input disabled");
    a_type_legal: assert property (@(posedge sys_clk) disable iff (!resetn)
        (type_reg <= DSL_TYPE_BIN_COMP) || (type_reg == DSL_TYPE_DISABLED))
        else $error("input type holds illegal code");
    a_strobe_legal: assert property (@(posedge sys_clk) disable iff (!resetn)
        strobe_reg <= DSL_STROBE_GATED)
        else $error("strobe mode holds illegal code");
    a_unit_legal: assert property (@(posedge sys_clk) disable iff (!resetn)
        unit_reg <= DSL_UNIT_MAX)
        else $error("speed unit holds illegal code");
    a_unit_frozen: assert property (@(posedge sys_clk) disable iff (!resetn)
        (drive_running && reg_wr && reg_addr == DSL_A_UNIT) |=> $stable(unit_reg))
        else $error("speed unit changed while running");
    a_hold_release: assert property (@(posedge sys_clk) disable iff (!resetn)
        (strobe_reg == DSL_STROBE_GATED && !strobe_s) |=> $stable(raw_reg))
        else $error("value changed with strobe released");
    a_bcd_reject: assert property (@(posedge sys_clk) disable iff (!resetn)
        (sample_en && is_bcd && !bcd_ok(word_s)) |=> ($stable(raw_reg) && bcd_err_reg))
        else $error("bad bcd digit was accepted");
    a_update_cause: assert property (@(posedge sys_clk) disable iff (!resetn)
        !$stable(raw_reg) |-> ($past(sample_en) && $past(word_s) == $past(word_prev_reg)))
        else $error("value updated without a sample");
    a_pass_through: assert property (@(posedge sys_clk) disable iff (!resetn)
        (active && pass) |=> setpoint_value == 16'($past(raw_reg)))
        else $error("pass-through setpoint differs from input");
endmodule

// File: verification/dsl_plc_model.sv
/*
 * model of the controller that drives the twelve setpoint pins and the
 * read strobe. assumes the bench sets want_word and want_strobe.
 */
`timescale 1ns/100ps
module dsl_plc_model #(
    parameter int unsigned SKEW_NS = 7
) (
    input  wire logic [11:0] want_word,
    input  wire logic        want_strobe,
    output      logic [11:0] lines,
    output      logic        strobe
);
    // ----------------------------------------------------------------
    // pins
    // ----------------------------------------------------------------
    // skewed, off-edge changes: open-collector outputs settle unrelated
    // to the drive clock
    initial begin
        lines  = 12'h000;
        strobe = 1'b0;
    end
    always @(want_word) begin
        lines <= #(SKEW_NS) want_word;
    end
    // strobe lags the data so the word is settled when it opens
    always @(want_strobe) begin
        strobe <= #(SKEW_NS + 3) want_strobe;
    end
endmodule

// File: verification/dsl_setpoint_latch_bench.sv
/*
 * self-checking bench of the setpoint latch: register port, decode,
 * strobe gating, run lock and scaling. assumes dsl_pkg and the model.
 */
`timescale 1ns/100ps
module dsl_setpoint_latch_bench;
    import dsl_pkg::*;
    logic        sys_clk;
    logic        resetn;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic [11:0] lines;
    logic        strobe;
    logic        drive_running;
    logic [15:0] sp_value;
    logic        sp_valid;
    logic        comp_en;
    logic [1:0]  speed_unit;
    logic        input_active;
    logic [11:0] want_word;
    logic        want_strobe;
    int          fails;
    int          n_tests;
    int          cycles;

    dsl_setpoint_latch u_dsl_setpoint_latch (.sys_clk(sys_clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .setpoint_input_lines(lines), .read_strobe(strobe),
        .drive_running(drive_running), .setpoint_value(sp_value),
        .setpoint_valid(sp_valid), .compensation_enable(comp_en),
        .speed_unit(speed_unit), .input_active(input_active));
    dsl_plc_model u_dsl_plc_model (.want_word(want_word), .want_strobe(want_strobe),
        .lines(lines), .strobe(strobe));

    // ----------------------------------------------------------------
    // clock and watchdog
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // whole run is well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fails = fails + 1;
            close_out();
        end
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [15:0] exp, input string what);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp, what);
    endtask
    task automatic pins(input logic [11:0] w);
        @(posedge sys_clk);
        want_word <= w;
        repeat (10) @(posedge sys_clk);
        #1;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rdc(DSL_A_TYPE, 16'd9999, "type");
        rdc(DSL_A_STROBE, 16'h0000, "strobe mode");
        rdc(DSL_A_UNIT, 16'h0001, "unit");
        rdc(4'hf, 16'h0000, "unmapped");
        chk({15'h0, input_active}, 16'h0000, "active");
        chk({14'h0, speed_unit}, 16'h0001, "unit out");
        pins(12'h123);
        chk({15'h0, sp_valid}, 16'h0000, "valid idle");
        chk(sp_value, 16'h0000, "value idle");
    endtask
    task automatic t_ranges();
        wr(DSL_A_TYPE, 16'h0004);
        rdc(DSL_A_TYPE, 16'd9999, "type 4");
        wr(DSL_A_STROBE, 16'h0002);
        rdc(DSL_A_STROBE, 16'h0000, "strobe 2");
        wr(DSL_A_UNIT, 16'h0003);
        rdc(DSL_A_UNIT, 16'h0001, "unit 3");
        for (int c = 0; c < 4; c++) begin
            wr(DSL_A_TYPE, 16'(c));
            rdc(DSL_A_TYPE, 16'(c), "type code");
            chk({15'h0, comp_en}, {15'h0, c >= 2}, "comp");
            chk({15'h0, input_active}, 16'h0001, "on");
        end
        wr(DSL_A_TYPE, 16'd9999);
        #1;
        chk({15'h0, input_active}, 16'h0000, "off");
    endtask
    task automatic t_decode();
        wr(DSL_A_BCD_GAIN, 16'd9999);
        wr(DSL_A_BIN_GAIN, 16'd9999);
        wr(DSL_A_TYPE, DSL_TYPE_BCD);
        pins(12'h123);
        rdc(DSL_A_RAW, 16'd123, "bcd raw");
        chk(sp_value, 16'd123, "bcd pass");
        chk({15'h0, sp_valid}, 16'h0001, "valid");
        pins(12'h999);
        chk(sp_value, 16'd999, "bcd full");
        pins(12'h1a3);
        chk(sp_value, 16'd999, "bad digit");
        rdc(DSL_A_STATUS, 16'h0017, "bcd error flag");
        wr(DSL_A_TYPE, DSL_TYPE_BIN);
        pins(12'hfff);
        chk(sp_value, 16'd4095, "bin full");
        pins(12'h123);
        chk(sp_value, 16'h0123, "bin hex");
        @(posedge sys_clk);
        want_word <= 12'h456;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(sp_value, 16'h0123, "sync delay");
        repeat (8) @(posedge sys_clk);
        #1;
        chk(sp_value, 16'h0456, "sync word");
    endtask
    task automatic t_strobe();
        wr(DSL_A_STROBE, DSL_STROBE_GATED);
        pins(12'h222);
        chk(sp_value, 16'h0456, "gate closed");
        want_strobe <= 1'b1;
        pins(12'h222);
        chk(sp_value, 16'h0222, "gate open");
        want_strobe <= 1'b0;
        pins(12'h222);
        pins(12'h333);
        chk(sp_value, 16'h0222, "held");
        wr(DSL_A_STROBE, DSL_STROBE_CONT);
        pins(12'h333);
        chk(sp_value, 16'h0333, "continuous");
    endtask
    task automatic t_unit();
        @(posedge sys_clk) drive_running <= 1'b1;
        wr(DSL_A_PERM, DSL_PERM_MAX);
        wr(DSL_A_UNIT, 16'h0002);
        rdc(DSL_A_UNIT, 16'h0001, "unit running");
        chk({14'h0, speed_unit}, 16'h0001, "unit kept");
        @(posedge sys_clk) drive_running <= 1'b0;
        wr(DSL_A_UNIT, 16'h0002);
        rdc(DSL_A_UNIT, 16'h0002, "unit stopped");
        chk({14'h0, speed_unit}, 16'h0002, "unit out");
        // lock value freezes every setting but the permission itself
        wr(DSL_A_PERM, DSL_PERM_LOCKED);
        wr(DSL_A_UNIT, 16'h0000);
        rdc(DSL_A_UNIT, 16'h0002, "unit locked");
        wr(DSL_A_PERM, DSL_PERM_RST);
    endtask
    task automatic t_scale();
        int exp;
        wr(DSL_A_TYPE, DSL_TYPE_BCD);
        wr(DSL_A_BCD_BIAS, 16'd1000);
        wr(DSL_A_BCD_GAIN, 16'd5000);
        pins(12'h000);
        chk(sp_value, 16'd1000, "bias");
        pins(12'h999);
        chk(sp_value, 16'd5000, "gain");
        exp = 1000 + (4000 * 500) / 999;
        pins(12'h500);
        chk(sp_value, 16'(exp), "midscale");
        rdc(DSL_A_SETPOINT, 16'(exp), "setpoint reg");
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        resetn        = 1'b0;
        reg_addr      = 4'h0;
        reg_wdata     = 16'h0000;
        reg_wr        = 1'b0;
        reg_rd        = 1'b0;
        drive_running = 1'b0;
        want_word     = 12'h000;
        want_strobe   = 1'b0;
        fails         = 0;
        n_tests       = 0;
        cycles        = 0;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset();
        t_ranges();
        t_decode();
        t_strobe();
        t_unit();
        t_scale();
        close_out();
    end
endmodule
